// ### rtl/rtccal_pkg.sv
package rtccal_pkg;
	localparam logic [6:0]  SLAVE_ADDR      = 7'h51;
	localparam logic [3:0]  OFS_CS1         = 4'h0;
	localparam logic [3:0]  OFS_CS2         = 4'h1;
	localparam logic [3:0]  OFS_SEC         = 4'h2;
	localparam logic [3:0]  OFS_MIN         = 4'h3;
	localparam logic [3:0]  OFS_HOUR        = 4'h4;
	localparam logic [3:0]  OFS_DATE        = 4'h5;
	localparam logic [3:0]  OFS_WDAY        = 4'h6;
	localparam logic [3:0]  OFS_MON         = 4'h7;
	localparam logic [3:0]  OFS_YEAR        = 4'h8;
	localparam logic [3:0]  OFS_MIN_MATCH   = 4'h9;
	localparam logic [3:0]  OFS_HOUR_MATCH  = 4'hA;
	localparam logic [3:0]  OFS_DATE_MATCH  = 4'hB;
	localparam logic [3:0]  OFS_WDAY_MATCH  = 4'hC;
	localparam logic [3:0]  OFS_CLKOUT      = 4'hD;
	localparam logic [3:0]  OFS_CD_CTRL     = 4'hE;
	localparam logic [3:0]  OFS_CD_VALUE    = 4'hF;
	localparam int          CS1_FACTORY_BIT = 7;
	localparam int          CS1_FREEZE_BIT  = 5;
	localparam int          CS1_OVERRIDE_BIT = 3;
	localparam int          CS2_AF_BIT      = 3;
	localparam int          CS2_TF_BIT      = 2;
	localparam int          CS2_AIE_BIT     = 1;
	localparam int          CS2_TIE_BIT     = 0;
	localparam int          CENTURY_BIT     = 7;
	localparam int          MATCH_OFF_BIT   = 7;
	localparam int          CD_EN_BIT       = 7;
	localparam logic [7:0]  REG_RESET       = 8'h00;
	localparam logic [7:0]  FIRST_DAY       = 8'h01;
	localparam logic [7:0]  FIRST_MONTH     = 8'h01;
	localparam logic [7:0]  SEC_TOP         = 8'h59;
	localparam logic [7:0]  HOUR_TOP        = 8'h23;
	localparam logic [7:0]  WDAY_TOP        = 8'h06;
	localparam logic [7:0]  MON_TOP         = 8'h12;
	localparam logic [7:0]  YEAR_TOP        = 8'h99;
	localparam logic [7:0]  BCD_ZERO        = 8'h00;
	localparam logic [14:0] PRESCALE_TOP    = 15'h7FFF;

	typedef enum logic [1:0] {
		PH_ADDR = 2'h0,
		PH_PTR  = 2'h1,
		PH_DATA = 2'h2
	} rtccal_phase_e;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RECV = 5'h02,
		ST_ACK  = 5'h04,
		ST_SEND = 5'h08,
		ST_MACK = 5'h10
	} rtccal_fsm_e;

	typedef struct packed {
		rtccal_fsm_e      fsm;
		rtccal_phase_e    phase;
		logic             rw;
		logic [3:0]       ptr;
		logic [7:0]       shift;
		logic [3:0]       bits;
		logic             busy;
		logic             pend;
		logic             tick_done;
		logic [14:0]      presc;
		logic             scl_meta;
		logic             scl_sync;
		logic             scl_prev;
		logic             sda_meta;
		logic             sda_sync;
		logic             sda_prev;
		logic             osc_meta;
		logic             osc_sync;
		logic             osc_prev;
		logic             sda_oe_n;
		logic             irq_n;
		logic [15:0][7:0] regs;
	} rtccal_state_s;

	function automatic logic [7:0] rtccal_bcd_step(input logic [7:0] v,
		input logic [7:0] top, input logic [7:0] bottom);
		if (v >= top)
			return bottom;
		else if (v[3:0] == 4'h9)
			return {v[7:4] + 4'h1, 4'h0};
		else
			return {v[7:4], v[3:0] + 4'h1};
	endfunction : rtccal_bcd_step

	function automatic logic [7:0] rtccal_last_day(input logic [7:0] mon,
		input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mon[4:0])
			5'h02:
				return leap ? 8'h29 : 8'h28;
			5'h04, 5'h06, 5'h09, 5'h11:
				return 8'h30;
			default:
				return 8'h31;
		endcase
	endfunction : rtccal_last_day

	function automatic logic [7:0] rtccal_field_mask(input logic [3:0] ofs);
		case (ofs)
			OFS_SEC, OFS_MIN:
				return 8'h7F;
			OFS_HOUR, OFS_DATE:
				return 8'h3F;
			OFS_WDAY:
				return 8'h07;
			OFS_MON:
				return 8'h9F;
			default:
				return 8'hFF;
		endcase
	endfunction : rtccal_field_mask

	function automatic logic rtccal_match_ok(input logic [7:0] m,
		input logic [7:0] cur);
		return m[MATCH_OFF_BIT] || (m[6:0] == cur[6:0]);
	endfunction : rtccal_match_ok
endpackage : rtccal_pkg

// ### rtl/rtccal_core.sv
module rtccal_core
	import rtccal_pkg::*;
(
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic osc_in,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe_n,
	output logic      irq_n
);
	rtccal_state_s st_reg;
	rtccal_state_s st_next;
	logic          wr_hit;
	logic          ld_byte;
	logic          tick_apply;
	logic          sec_tick;
	logic          run;
	logic          scl_rise;
	logic          scl_fall;
	logic          start_seen;
	logic          stop_seen;
	logic          alarm_set;
	logic          timer_set;
	logic [7:0]    wr_val;
	logic [7:0]    mon_step;

	// Open-drain: the pin only ever pulls low
	assign sda_out  = 1'b0;
	assign sda_oe_n = st_reg.sda_oe_n;
	assign irq_n    = st_reg.irq_n;

	always_comb
	begin
		st_next    = st_reg;
		wr_hit     = 1'b0;
		ld_byte    = 1'b0;
		sec_tick   = 1'b0;
		alarm_set  = 1'b0;
		timer_set  = 1'b0;
		wr_val     = REG_RESET;
		mon_step   = rtccal_bcd_step({3'b000,
			st_reg.regs[OFS_MON][4:0]}, MON_TOP, FIRST_MONTH);
		st_next.scl_meta = scl_in;
		st_next.scl_sync = st_reg.scl_meta;
		st_next.scl_prev = st_reg.scl_sync;
		st_next.sda_meta = sda_in;
		st_next.sda_sync = st_reg.sda_meta;
		st_next.sda_prev = st_reg.sda_sync;
		st_next.osc_meta = osc_in;
		st_next.osc_sync = st_reg.osc_meta;
		st_next.osc_prev = st_reg.osc_sync;
		scl_rise   = st_reg.scl_sync && !st_reg.scl_prev;
		scl_fall   = !st_reg.scl_sync && st_reg.scl_prev;
		start_seen = st_reg.scl_sync && st_reg.scl_prev
			&& st_reg.sda_prev && !st_reg.sda_sync;
		stop_seen  = st_reg.scl_sync && st_reg.scl_prev
			&& !st_reg.sda_prev && st_reg.sda_sync;

		run = !st_reg.regs[OFS_CS1][CS1_FACTORY_BIT]
			&& !st_reg.regs[OFS_CS1][CS1_FREEZE_BIT]
			&& !st_reg.regs[OFS_CS1][CS1_OVERRIDE_BIT];
		// Prescaler restarts from zero so the first second after a halt is full
		if (!run)
			st_next.presc = '0;
		else if (st_reg.osc_sync && !st_reg.osc_prev)
		begin
			if (st_reg.presc == PRESCALE_TOP)
			begin
				st_next.presc = '0;
				sec_tick = 1'b1;
			end
			else
				st_next.presc = st_reg.presc + 15'h0001;
		end
		// A second that falls inside a transfer waits for its end
		tick_apply = run && (st_reg.pend || sec_tick) && !st_reg.busy;
		st_next.pend = run && (st_reg.pend || sec_tick) && st_reg.busy;
		st_next.tick_done = tick_apply;

		if (tick_apply)
		begin
			st_next.regs[OFS_SEC] = rtccal_bcd_step(st_reg.regs[OFS_SEC],
				SEC_TOP, BCD_ZERO);
			if (st_reg.regs[OFS_SEC] >= SEC_TOP)
			begin
				st_next.regs[OFS_MIN] = rtccal_bcd_step(st_reg.regs[OFS_MIN],
					SEC_TOP, BCD_ZERO);
				if (st_reg.regs[OFS_MIN] >= SEC_TOP)
				begin
					st_next.regs[OFS_HOUR] = rtccal_bcd_step(
						st_reg.regs[OFS_HOUR], HOUR_TOP, BCD_ZERO);
					if (st_reg.regs[OFS_HOUR] >= HOUR_TOP)
					begin
						st_next.regs[OFS_WDAY] = rtccal_bcd_step(
							st_reg.regs[OFS_WDAY], WDAY_TOP, BCD_ZERO);
						st_next.regs[OFS_DATE] = rtccal_bcd_step(
							st_reg.regs[OFS_DATE],
							rtccal_last_day(st_reg.regs[OFS_MON],
							st_reg.regs[OFS_YEAR]), FIRST_DAY);
						if (st_reg.regs[OFS_DATE] >= rtccal_last_day(
							st_reg.regs[OFS_MON], st_reg.regs[OFS_YEAR]))
						begin
							st_next.regs[OFS_MON][4:0] =
								mon_step[4:0];
							if (st_reg.regs[OFS_MON][4:0] >= MON_TOP[4:0])
							begin
								st_next.regs[OFS_YEAR] = rtccal_bcd_step(
									st_reg.regs[OFS_YEAR], YEAR_TOP,
									BCD_ZERO);
								if (st_reg.regs[OFS_YEAR] >= YEAR_TOP)
									st_next.regs[OFS_MON][CENTURY_BIT] =
										!st_reg.regs[OFS_MON][CENTURY_BIT];
							end
						end
					end
				end
			end
			if (st_reg.regs[OFS_CD_CTRL][CD_EN_BIT]
				&& st_reg.regs[OFS_CD_VALUE] != BCD_ZERO)
			begin
				st_next.regs[OFS_CD_VALUE] =
					st_reg.regs[OFS_CD_VALUE] - 8'h01;
				timer_set = (st_reg.regs[OFS_CD_VALUE] == 8'h01);
			end
		end

		// Alarm is judged once per new minute, a cycle after the tick lands
		alarm_set = st_reg.tick_done && st_reg.regs[OFS_SEC] == BCD_ZERO
			&& !(st_reg.regs[OFS_MIN_MATCH][MATCH_OFF_BIT]
			&& st_reg.regs[OFS_HOUR_MATCH][MATCH_OFF_BIT]
			&& st_reg.regs[OFS_DATE_MATCH][MATCH_OFF_BIT]
			&& st_reg.regs[OFS_WDAY_MATCH][MATCH_OFF_BIT])
			&& rtccal_match_ok(st_reg.regs[OFS_MIN_MATCH],
				st_reg.regs[OFS_MIN])
			&& rtccal_match_ok(st_reg.regs[OFS_HOUR_MATCH],
				st_reg.regs[OFS_HOUR])
			&& rtccal_match_ok(st_reg.regs[OFS_DATE_MATCH],
				st_reg.regs[OFS_DATE])
			&& rtccal_match_ok(st_reg.regs[OFS_WDAY_MATCH],
				st_reg.regs[OFS_WDAY]);

		if (start_seen)
		begin
			st_next.busy     = 1'b1;
			st_next.fsm      = ST_RECV;
			st_next.phase    = PH_ADDR;
			st_next.bits     = 4'h0;
			st_next.sda_oe_n = 1'b1;
		end
		else if (stop_seen)
		begin
			st_next.busy     = 1'b0;
			st_next.fsm      = ST_IDLE;
			st_next.sda_oe_n = 1'b1;
		end
		else
		begin
			unique case (st_reg.fsm)
				ST_IDLE:
					st_next.sda_oe_n = 1'b1;
				ST_RECV:
				begin
					if (scl_rise && st_reg.bits != 4'h8)
					begin
						st_next.shift = {st_reg.shift[6:0], st_reg.sda_sync};
						st_next.bits  = st_reg.bits + 4'h1;
					end
					else if (scl_fall && st_reg.bits == 4'h8)
					begin
						st_next.bits     = 4'h0;
						st_next.fsm      = ST_ACK;
						st_next.sda_oe_n = 1'b0;
						if (st_reg.phase == PH_ADDR)
						begin
							st_next.rw = st_reg.shift[0];
							if (st_reg.shift[7:1] != SLAVE_ADDR)
							begin
								st_next.fsm      = ST_IDLE;
								st_next.sda_oe_n = 1'b1;
							end
						end
						else if (st_reg.phase == PH_PTR)
							st_next.ptr = st_reg.shift[3:0];
						else
						begin
							wr_hit = 1'b1;
							wr_val = st_reg.shift & rtccal_field_mask(st_reg.ptr);
							// Flags only clear on a written zero
							if (st_reg.ptr == OFS_CS2)
							begin
								wr_val[CS2_AF_BIT] = wr_val[CS2_AF_BIT]
									&& st_reg.regs[OFS_CS2][CS2_AF_BIT];
								wr_val[CS2_TF_BIT] = wr_val[CS2_TF_BIT]
									&& st_reg.regs[OFS_CS2][CS2_TF_BIT];
							end
							st_next.regs[st_reg.ptr] = wr_val;
							st_next.ptr = st_reg.ptr + 4'h1;
						end
					end
				end
				ST_ACK:
				begin
					if (scl_fall)
					begin
						st_next.sda_oe_n = 1'b1;
						st_next.fsm      = ST_RECV;
						if (st_reg.phase == PH_ADDR && st_reg.rw)
						begin
							ld_byte          = 1'b1;
							st_next.fsm      = ST_SEND;
							st_next.shift    = st_reg.regs[st_reg.ptr];
							st_next.sda_oe_n = st_reg.regs[st_reg.ptr][7];
							st_next.ptr      = st_reg.ptr + 4'h1;
						end
						else if (st_reg.phase == PH_ADDR)
							st_next.phase = PH_PTR;
						else
							st_next.phase = PH_DATA;
					end
				end
				ST_SEND:
				begin
					if (scl_fall)
					begin
						st_next.bits = st_reg.bits + 4'h1;
						if (st_reg.bits == 4'h7)
						begin
							st_next.fsm      = ST_MACK;
							st_next.sda_oe_n = 1'b1;
						end
						else
						begin
							st_next.shift    = {st_reg.shift[6:0], 1'b0};
							st_next.sda_oe_n = st_reg.shift[6];
						end
					end
				end
				ST_MACK:
				begin
					// A not-acknowledge ends the burst; the stop follows
					if (scl_rise && st_reg.sda_sync)
						st_next.fsm = ST_IDLE;
					else if (scl_fall)
					begin
						ld_byte          = 1'b1;
						st_next.bits     = 4'h0;
						st_next.fsm      = ST_SEND;
						st_next.shift    = st_reg.regs[st_reg.ptr];
						st_next.sda_oe_n = st_reg.regs[st_reg.ptr][7];
						st_next.ptr      = st_reg.ptr + 4'h1;
					end
				end
				default:
				begin
					st_next.fsm      = ST_IDLE;
					st_next.sda_oe_n = 1'b1;
				end
			endcase
		end

		// Hardware set wins over a host clear in the same cycle
		if (alarm_set)
			st_next.regs[OFS_CS2][CS2_AF_BIT] = 1'b1;
		if (timer_set)
			st_next.regs[OFS_CS2][CS2_TF_BIT] = 1'b1;
		st_next.irq_n = !((st_next.regs[OFS_CS2][CS2_AF_BIT]
			&& st_next.regs[OFS_CS2][CS2_AIE_BIT])
			|| (st_next.regs[OFS_CS2][CS2_TF_BIT]
			&& st_next.regs[OFS_CS2][CS2_TIE_BIT]));
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_reg                 <= '0;
			st_reg.fsm             <= ST_IDLE;
			st_reg.phase           <= PH_ADDR;
			st_reg.sda_oe_n        <= 1'b1;
			st_reg.irq_n           <= 1'b1;
			st_reg.regs[OFS_DATE]  <= FIRST_DAY;
			st_reg.regs[OFS_MON]   <= FIRST_MONTH;
		end
		else
			st_reg <= st_next;
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	a_factory_hold: assert property (
		st_reg.regs[OFS_CS1][CS1_FACTORY_BIT] && !wr_hit
		|=> $stable(st_reg.regs[OFS_SEC]))
		else $error("seconds moved in factory mode");
	a_freeze_hold: assert property (
		st_reg.regs[OFS_CS1][CS1_FREEZE_BIT] && !wr_hit
		##1 !wr_hit |=> $stable(st_reg.regs[OFS_SEC]))
		else $error("seconds moved while frozen");
	a_override_presc: assert property (
		st_reg.regs[OFS_CS1][CS1_OVERRIDE_BIT] |=> st_reg.presc == '0)
		else $error("prescaler ran with override set");
	a_alarm_quiet: assert property (
		!st_reg.regs[OFS_CS2][CS2_AIE_BIT]
		&& !(st_reg.regs[OFS_CS2][CS2_TF_BIT]
		&& st_reg.regs[OFS_CS2][CS2_TIE_BIT]) |-> st_reg.irq_n)
		else $error("interrupt with alarm disabled");
	a_timer_quiet: assert property (
		!st_reg.regs[OFS_CS2][CS2_TIE_BIT]
		&& !(st_reg.regs[OFS_CS2][CS2_AF_BIT]
		&& st_reg.regs[OFS_CS2][CS2_AIE_BIT]) |-> st_reg.irq_n)
		else $error("interrupt with countdown disabled");
	a_century_cause: assert property (
		$changed(st_reg.regs[OFS_MON][CENTURY_BIT])
		|-> $past(wr_hit) || $past(st_reg.regs[OFS_YEAR]) == YEAR_TOP)
		else $error("century flipped without cause");
	a_ptr_advance: assert property (
		ld_byte |=> st_reg.ptr == $past(st_reg.ptr) + 4'h1)
		else $error("pointer did not advance");
	a_seconds_width: assert property (
		st_reg.regs[OFS_SEC][7] == 1'b0)
		else $error("seconds bit 7 set");
	a_hours_width: assert property (
		st_reg.regs[OFS_HOUR][7:6] == 2'b00)
		else $error("hours upper bits set");
	a_month_width: assert property (
		st_reg.regs[OFS_MON][6:5] == 2'b00)
		else $error("month reserved bits set");
	a_addr_ack: assert property (
		$fell(st_reg.sda_oe_n) && st_reg.fsm == ST_ACK
		&& st_reg.phase == PH_ADDR |-> st_reg.shift[7:1] == SLAVE_ADDR)
		else $error("acknowledged a foreign address");
	a_busy_hold: assert property (
		st_reg.busy && !wr_hit |=> $stable(st_reg.regs[OFS_SEC]))
		else $error("time advanced during transfer");

	c_read_burst: cover property (ld_byte ##[1:400] ld_byte);
	c_alarm_flag: cover property (alarm_set);
	c_timer_flag: cover property (timer_set);
endmodule : rtccal_core

// ### sim/rtccal_host.sv
module rtccal_host
	import rtccal_pkg::*;
(
	input  wire logic clock,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_pull
);
	timeunit 1ns;
	timeprecision 100ps;

	// Bus idles with both lines released to their pull-ups
	initial
	begin
		scl = 1'h1;
		sda_pull = 1'h0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : wait_clk

	// Also serves as repeated start: scl is low when entered mid-transfer
	task automatic bus_start();
		sda_pull = 1'h0;
		wait_clk(10);
		scl = 1'h1;
		wait_clk(10);
		sda_pull = 1'h1;
		wait_clk(10);
		scl = 1'h0;
		wait_clk(3);
	endtask : bus_start

	task automatic bus_stop();
		sda_pull = 1'h1;
		wait_clk(10);
		scl = 1'h1;
		wait_clk(10);
		sda_pull = 1'h0;
		wait_clk(10);
	endtask : bus_stop

	// Data moves only 3 clocks after scl falls, never in step with it
	task automatic bus_bit(input logic b, output logic r);
		sda_pull = !b;
		wait_clk(10);
		scl = 1'h1;
		wait_clk(10);
		r = sda_line;
		scl = 1'h0;
		wait_clk(3);
	endtask : bus_bit

	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bus_bit(d[i], r);
		bus_bit(1'h1, r);
		ack = !r;
	endtask : send_byte

	task automatic get_byte(input logic last, output logic [7:0] d);
		logic r;
		d = 8'h00;
		for (int i = 0; i < 8; i++)
		begin
			bus_bit(1'h1, r);
			d = {d[6:0], r};
		end
		bus_bit(last, r);
	endtask : get_byte

	task automatic write_regs(input logic [3:0] ptr, input logic [7:0] d [16],
		input int n, output logic ok);
		logic a;
		bus_start();
		send_byte({SLAVE_ADDR, 1'h0}, a);
		ok = a;
		send_byte({4'h0, ptr}, a);
		ok &= a;
		for (int i = 0; i < n; i++)
		begin
			send_byte(d[i], a);
			ok &= a;
		end
		bus_stop();
	endtask : write_regs

	task automatic read_regs(input logic [3:0] ptr, input int n,
		output logic [7:0] d [16], output logic ok);
		logic a;
		bus_start();
		send_byte({SLAVE_ADDR, 1'h0}, a);
		ok = a;
		send_byte({4'h0, ptr}, a);
		ok &= a;
		bus_start();
		send_byte({SLAVE_ADDR, 1'h1}, a);
		ok &= a;
		for (int i = 0; i < n; i++)
			get_byte(i == n - 1, d[i]);
		bus_stop();
	endtask : read_regs
endmodule : rtccal_host

// ### sim/tb_rtc_calendar_register_map.sv
module tb_rtc_calendar_register_map
	import rtccal_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic       clock;
	logic       sys_rst;
	logic       osc_in;
	logic       scl;
	logic       sda_pull;
	logic       sda_out;
	logic       sda_oe_n;
	logic       irq_n;
	wire logic  sda_line;
	int         bad_count;
	int         check_count;
	logic [7:0] wd [16];
	logic [7:0] rd [16];
	logic       ok;

	// Pull-up: the line is low only while some party pulls it
	assign sda_line = !(sda_pull || (!sda_oe_n && !sda_out));

	rtccal_core uut (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.osc_in   (osc_in),
		.scl_in   (scl),
		.sda_in   (sda_line),
		.sda_out  (sda_out),
		.sda_oe_n (sda_oe_n),
		.irq_n    (irq_n)
	);

	rtccal_host host (
		.clock    (clock),
		.sda_line (sda_line),
		.scl      (scl),
		.sda_pull (sda_pull)
	);

	initial
		clock = 1'h0;
	always #2.5 clock = !clock;

	// Oscillator runs, but a whole second would take far longer than the run
	always
	begin
		repeat (4) @(posedge clock);
		#1;
		osc_in = !osc_in;
	end

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		check_count++;
		if (got !== exp)
		begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			bad_count++;
		end
	endtask : chk

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	task automatic t_reset_map();
		host.read_regs(OFS_CS1, 16, rd, ok);
		chk("reset read ack", 8'h01, {7'h00, ok});
		for (int i = 0; i < 16; i++)
			chk("reset value", (i == 5 || i == 7) ? 8'h01 : 8'h00, rd[i]);
		$display("test reset_map done");
	endtask : t_reset_map

	task automatic t_init_time();
		wd = '{8'h00, 8'h00, 8'h02, 8'h03, 8'h14, 8'h23, 8'h01, 8'h07,
			8'h12, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		host.write_regs(OFS_CS1, wd, 9, ok);
		chk("init write ack", 8'h01, {7'h00, ok});
		host.read_regs(OFS_SEC, 7, rd, ok);
		for (int i = 0; i < 7; i++)
			chk("time burst", wd[i + 2], rd[i]);
		host.read_regs(OFS_CS1, 2, rd, ok);
		chk("control one", 8'h00, rd[0]);
		chk("control two", 8'h00, rd[1]);
		$display("test init_time done");
	endtask : t_init_time

	task automatic t_masks();
		logic [3:0] ofs [8] = '{OFS_SEC, OFS_MIN, OFS_HOUR, OFS_DATE,
			OFS_WDAY, OFS_MON, OFS_MON, OFS_YEAR};
		logic [7:0] wv [8] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
			8'h07, 8'h99};
		logic [7:0] ev [8] = '{8'h7F, 8'h7F, 8'h3F, 8'h3F, 8'h07, 8'h9F,
			8'h07, 8'h99};
		for (int i = 0; i < 8; i++)
		begin
			wd[0] = wv[i];
			host.write_regs(ofs[i], wd, 1, ok);
			host.read_regs(ofs[i], 1, rd, ok);
			chk("field mask", ev[i], rd[0]);
		end
		$display("test masks done");
	endtask : t_masks

	task automatic t_address();
		logic       a;
		logic [7:0] bad [2] = '{8'hA4, 8'hD0};
		wd[0] = 8'h45;
		host.write_regs(OFS_SEC, wd, 1, ok);
		for (int i = 0; i < 2; i++)
		begin
			host.bus_start();
			host.send_byte(bad[i], a);
			chk("foreign address ack", 8'h00, {7'h00, a});
			host.send_byte({4'h0, OFS_SEC}, a);
			host.send_byte(8'h33, a);
			host.bus_stop();
		end
		host.read_regs(OFS_SEC, 1, rd, ok);
		chk("seconds kept", 8'h45, rd[0]);
		chk("read ack after refusal", 8'h01, {7'h00, ok});
		$display("test address done");
	endtask : t_address

	task automatic t_wrap();
		wd[0] = 8'h5A;
		wd[1] = 8'h00;
		host.write_regs(OFS_CD_VALUE, wd, 2, ok);
		host.read_regs(OFS_CD_VALUE, 2, rd, ok);
		chk("last register", 8'h5A, rd[0]);
		chk("wrapped register", 8'h00, rd[1]);
		$display("test wrap done");
	endtask : t_wrap

	task automatic t_ctrl();
		logic [7:0] cv [4] = '{8'h80, 8'h20, 8'h08, 8'h00};
		for (int i = 0; i < 4; i++)
		begin
			wd[0] = cv[i];
			host.write_regs(OFS_CS1, wd, 1, ok);
			host.read_regs(OFS_CS1, 1, rd, ok);
			chk("control one bits", cv[i], rd[0]);
		end
		// Writing one to a flag must not set it, so no interrupt may follow
		wd[0] = 8'h0F;
		host.write_regs(OFS_CS2, wd, 1, ok);
		host.read_regs(OFS_CS2, 1, rd, ok);
		chk("control two bits", 8'h03, rd[0]);
		chk("irq level", 8'h01, {7'h00, irq_n});
		wd[0] = 8'h00;
		host.write_regs(OFS_CS2, wd, 1, ok);
		chk("irq level idle", 8'h01, {7'h00, irq_n});
		$display("test ctrl done");
	endtask : t_ctrl

	initial
	begin
		sys_rst = 1'h1;
		osc_in = 1'h0;
		bad_count = 0;
		check_count = 0;
		repeat (8) @(posedge clock);
		#1;
		sys_rst = 1'h0;
		host.wait_clk(5);
		t_reset_map();
		t_init_time();
		t_masks();
		t_address();
		t_wrap();
		t_ctrl();
		end_of_test();
	end

	initial
	begin
		repeat (90000) @(posedge clock);
		bad_count++;
		$display("[FAIL] run length expected under 90000 seen over");
		end_of_test();
	end
endmodule : tb_rtc_calendar_register_map
